// ### design/lffe_config_regs.sv
module lffe_config_regs
  import lffe_pkg::*;
#(
  parameter int unsigned MS_CYCLES = LFFE_MS_CYCLES
)
(
  // Clock and reset
  input  wire logic       I_CLOCK,
  input  wire logic       I_RESET,
  // Register access
  input  wire logic       I_WR_STROBE,
  input  wire logic       I_RD_STROBE,
  input  wire logic [3:0] I_ADDR,
  input  wire logic [8:0] I_WDATA,
  output logic      [8:0] O_RDATA,
  output logic            O_RD_VALID,
  // Front end pins
  input  wire logic       I_DEMOD_DATA,
  input  wire logic       I_CARRIER_CLOCK,
  input  wire logic       I_AGC_REGULATING,
  input  wire logic       I_RSSI_LEVEL,
  input  wire logic       I_ALARM_EXPIRED,
  // Data pin
  output logic            O_RECEIVE_DATA_PIN,
  output logic            O_SIGNAL_STRENGTH_PULLDOWN,
  // Analog settings
  output logic            O_CHANNEL_ENABLE,
  output logic      [5:0] O_ANTENNA_TUNING_CAP,
  output logic      [4:0] O_SENSITIVITY_CUT_DB,
  output logic      [6:0] O_MIN_MODULATION_DEPTH,
  output logic      [2:0] O_FILTER_LOW_TIME_MS,
  output logic            O_FILTER_LOW_MET,
  // Status
  output logic            O_AGC_ACTIVE,
  output logic            O_PARITY_ERROR_FLAG,
  output logic            O_ALERT_N
);
  logic [8:0] cfg [0:LFFE_REG_N-1];

  // Register decode
  wire        wr_hit = I_WR_STROBE && (I_ADDR <= LFFE_ADDR_LAST);
  wire        rd_hit = I_RD_STROBE && (I_ADDR <= LFFE_ADDR_LAST);
  wire [2:0]  index  = I_ADDR[2:0];
  // Unimplemented bits never store, so reads of them return zero
  wire [8:0]  wdata  = (I_ADDR == LFFE_ADDR_REG3) ? (I_WDATA & LFFE_REG3_MASK) : I_WDATA;
  wire [8:0]  next_rdata = rd_hit ? cfg[index] : LFFE_REG_RESET;

  // Field views
  wire [1:0]  low_time_code    = cfg[0][LFFE_LOWT_LSB +: 2];
  wire        alert_source     = cfg[0][LFFE_ALRT_BIT];
  wire        channel_disable  = cfg[0][LFFE_CHDIS_BIT];
  wire [1:0]  output_type      = cfg[1][LFFE_OTYPE_LSB +: 2];
  wire [5:0]  tuning_cap       = cfg[1][LFFE_TUNE_LSB +: 6];
  wire        pulldown_bit     = cfg[2][LFFE_PULL_BIT];
  wire        clock_divide     = cfg[2][LFFE_CDIV_BIT];
  wire [3:0]  sensitivity_code = cfg[4][LFFE_SENS_LSB +: 4];
  wire        agc_gated        = cfg[5][LFFE_AGCG_BIT];
  wire [1:0]  mod_depth_code   = cfg[5][LFFE_MODD_LSB +: 2];

  // Pin synchronisers
  logic [LFFE_PIN_N-1:0] pin_raw;
  logic [LFFE_PIN_N-1:0] sync1;
  logic [LFFE_PIN_N-1:0] sync2;
  logic [LFFE_PIN_N-1:0] sync3;
  logic [LFFE_PIN_N-1:0] pin;

  assign pin_raw[LFFE_PIN_DEMOD] = I_DEMOD_DATA;
  assign pin_raw[LFFE_PIN_CARR]  = I_CARRIER_CLOCK;
  assign pin_raw[LFFE_PIN_AGC]   = I_AGC_REGULATING;
  assign pin_raw[LFFE_PIN_RSSI]  = I_RSSI_LEVEL;
  assign pin_raw[LFFE_PIN_ALARM] = I_ALARM_EXPIRED;

  genvar g;
  generate
    for (g = 0; g < LFFE_PIN_N; g++)
    begin : g_sync
      // A change is taken only when stages two and three agree
      always_ff @(posedge I_CLOCK or posedge I_RESET)
      begin
        if (I_RESET)
        begin
          sync1[g] <= 1'b0;
          sync2[g] <= 1'b0;
          sync3[g] <= 1'b0;
          pin[g]   <= 1'b0;
        end
        else
        begin
          sync1[g] <= pin_raw[g];
          sync2[g] <= sync1[g];
          sync3[g] <= sync2[g];
          if (sync2[g] == sync3[g])
            pin[g] <= sync3[g];
        end
      end
    end
  endgenerate

  // Row parity: each row must hold an odd count of ones
  logic [LFFE_REG_N-1:0] row_bad;
  generate
    for (g = 0; g < LFFE_REG_N; g++)
    begin : g_parity
      assign row_bad[g] = ~^cfg[g];
    end
  endgenerate
  wire parity_error = |row_bad;

  // Register storage
  generate
    for (g = 0; g < LFFE_REG_N; g++)
    begin : g_reg
      always_ff @(posedge I_CLOCK or posedge I_RESET)
      begin
        if (I_RESET)
          cfg[g] <= LFFE_REG_RESET;
        else if (wr_hit && index == 3'(g))
          cfg[g] <= wdata;
      end
    end
  endgenerate

  // Filter low time and carrier divider
  logic low_met;
  logic carrier_out;

  lffe_low_timer #(
    .MS_CYCLES (MS_CYCLES)
  ) u_low_timer (
    .i_clock (I_CLOCK),
    .i_reset (I_RESET),
    .i_level (pin[LFFE_PIN_DEMOD]),
    .i_code  (low_time_code),
    .o_met   (low_met)
  );

  lffe_clock_divider u_clock_divider (
    .i_clock   (I_CLOCK),
    .i_reset   (I_RESET),
    .i_carrier (pin[LFFE_PIN_CARR]),
    .i_divide  (clock_divide),
    .o_clock   (carrier_out)
  );

  // Data path selection
  wire agc_active = pin[LFFE_PIN_AGC];
  // A disabled channel passes no demod data; carrier and RSSI output types are not gated by it
  wire demod_pass = pin[LFFE_PIN_DEMOD] && !channel_disable && (!agc_gated || agc_active);
  wire rssi_mode  = (output_type != LFFE_OTYPE_DEMOD) && (output_type != LFFE_OTYPE_CARR);
  wire next_data_pin = (output_type == LFFE_OTYPE_DEMOD) ? demod_pass :
                       (output_type == LFFE_OTYPE_CARR)  ? carrier_out :
                       pin[LFFE_PIN_RSSI];
  // The user owns the pulldown only in signal-strength mode
  wire next_pulldown = rssi_mode && pulldown_bit;
  wire next_alert_n  = !(parity_error || (alert_source && pin[LFFE_PIN_ALARM]));
  wire [4:0] next_sens_db = {sensitivity_code, 1'b0};

  // Read port
  always_ff @(posedge I_CLOCK or posedge I_RESET)
  begin
    if (I_RESET)
    begin
      O_RDATA    <= LFFE_REG_RESET;
      O_RD_VALID <= 1'b0;
    end
    else
    begin
      O_RDATA    <= next_rdata;
      O_RD_VALID <= I_RD_STROBE;
    end
  end

  // Registered outputs; after reset the rows hold bad parity, so alert starts low
  always_ff @(posedge I_CLOCK or posedge I_RESET)
  begin
    if (I_RESET)
    begin
      O_RECEIVE_DATA_PIN         <= 1'b0;
      O_SIGNAL_STRENGTH_PULLDOWN <= 1'b0;
      O_CHANNEL_ENABLE           <= 1'b1;
      O_ANTENNA_TUNING_CAP       <= '0;
      O_SENSITIVITY_CUT_DB       <= '0;
      O_MIN_MODULATION_DEPTH     <= LFFE_MOD_33;
      O_FILTER_LOW_TIME_MS       <= LFFE_LOWT_1MS;
      O_FILTER_LOW_MET           <= 1'b0;
      O_AGC_ACTIVE               <= 1'b0;
      O_PARITY_ERROR_FLAG        <= 1'b1;
      O_ALERT_N                  <= 1'b0;
    end
    else
    begin
      O_RECEIVE_DATA_PIN         <= next_data_pin;
      O_SIGNAL_STRENGTH_PULLDOWN <= next_pulldown;
      O_CHANNEL_ENABLE           <= !channel_disable;
      O_ANTENNA_TUNING_CAP       <= tuning_cap;
      O_SENSITIVITY_CUT_DB       <= next_sens_db;
      O_MIN_MODULATION_DEPTH     <= lffe_mod_depth(mod_depth_code);
      O_FILTER_LOW_TIME_MS       <= lffe_low_time_ms(low_time_code);
      O_FILTER_LOW_MET           <= low_met;
      O_AGC_ACTIVE               <= agc_gated && agc_active;
      O_PARITY_ERROR_FLAG        <= parity_error;
      O_ALERT_N                  <= next_alert_n;
    end
  end

  // Checks
  a_write_stores: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
    I_WR_STROBE && I_ADDR == LFFE_ADDR_REG0 |=> cfg[0] == $past(I_WDATA))
    else $error("register 0 write not stored");

  a_read_answer: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
    I_RD_STROBE && !I_WR_STROBE && I_ADDR == LFFE_ADDR_REG0 |=> O_RD_VALID && O_RDATA == cfg[0])
    else $error("read of register 0 returned wrong data");

  a_reset_zero: assert property (@(posedge I_CLOCK)
    $fell(I_RESET) |-> cfg[0] == LFFE_REG_RESET && cfg[5] == LFFE_REG_RESET)
    else $error("register not zero after reset");

  a_reg3_unimpl: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
    I_RD_STROBE && I_ADDR == LFFE_ADDR_REG3 |=> O_RDATA[8:7] == 2'h0)
    else $error("unimplemented bits read as one");

  a_alert_cause: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
    !O_ALERT_N |-> $past(parity_error) || ($past(alert_source) && $past(pin[LFFE_PIN_ALARM])))
    else $error("alert low without cause");

  a_parity_alert: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
    parity_error |=> O_PARITY_ERROR_FLAG && !O_ALERT_N)
    else $error("parity error not flagged");

  a_channel_enable: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
    ##1 O_CHANNEL_ENABLE == !$past(cfg[0][LFFE_CHDIS_BIT]))
    else $error("channel enable not inverted bit");

  a_pulldown_mode: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
    O_SIGNAL_STRENGTH_PULLDOWN |-> $past(cfg[1][LFFE_OTYPE_LSB + 1]) && $past(cfg[2][LFFE_PULL_BIT]))
    else $error("pulldown outside signal-strength mode");

  a_demod_gate: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
    output_type == LFFE_OTYPE_DEMOD && agc_gated && !agc_active |=> !O_RECEIVE_DATA_PIN)
    else $error("demod passed before AGC regulates");

  a_sens_step: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
    ##1 O_SENSITIVITY_CUT_DB == 5'($past(sensitivity_code) * 2))
    else $error("sensitivity step not 2 dB");

  a_tuning_copy: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
    I_WR_STROBE && I_ADDR == LFFE_ADDR_REG1 |=> ##1 O_ANTENNA_TUNING_CAP == $past(I_WDATA[LFFE_TUNE_LSB +: 6], 2))
    else $error("tuning code not applied");

  a_lowt_long: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
    low_time_code == 2'h3 |=> O_FILTER_LOW_TIME_MS == LFFE_LOWT_4MS)
    else $error("longest low time not selected");

  a_lowt_short: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
    !low_time_code[1] |=> O_FILTER_LOW_TIME_MS == LFFE_LOWT_1MS)
    else $error("short low time codes not 1 ms");

  a_depth_coarse: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
    mod_depth_code == 2'h1 |=> O_MIN_MODULATION_DEPTH == LFFE_MOD_60)
    else $error("depth code 1 not 60 percent");

  a_depth_fine: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
    mod_depth_code == 2'h3 |=> O_MIN_MODULATION_DEPTH == LFFE_MOD_8)
    else $error("depth code 3 not 8 percent");

  a_carrier_pass: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
    output_type == LFFE_OTYPE_CARR && !clock_divide |=> O_RECEIVE_DATA_PIN == $past(pin[LFFE_PIN_CARR]))
    else $error("undivided carrier not on data pin");

  a_rssi_pass: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
    output_type[1] |=> O_RECEIVE_DATA_PIN == $past(pin[LFFE_PIN_RSSI]))
    else $error("signal strength not on data pin");

  a_channel_off: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
    channel_disable && output_type == LFFE_OTYPE_DEMOD |=> !O_RECEIVE_DATA_PIN)
    else $error("disabled channel passed data");

  a_unmapped_write: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
    I_WR_STROBE && I_ADDR > LFFE_ADDR_LAST |=> $stable(cfg[0]) && $stable(cfg[5]))
    else $error("write outside the bank changed a register");

  a_reg3_store: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
    I_WR_STROBE && I_ADDR == LFFE_ADDR_REG3 |=> (cfg[3] & ~LFFE_REG3_MASK) == LFFE_REG_RESET)
    else $error("unimplemented bits stored");

  a_parity_clear: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
    !parity_error |=> !O_PARITY_ERROR_FLAG)
    else $error("parity flag set with good rows");

  a_alert_quiet: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
    !parity_error && !alert_source |=> O_ALERT_N)
    else $error("alert low with no parity error");

  a_agc_status: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
    agc_gated && agc_active |=> O_AGC_ACTIVE)
    else $error("agc status not set while regulating");

  a_pulldown_on: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
    output_type[1] && pulldown_bit |=> O_SIGNAL_STRENGTH_PULLDOWN)
    else $error("pulldown not on in signal-strength mode");

  a_read_idle: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
    !I_RD_STROBE |=> !O_RD_VALID && O_RDATA == LFFE_REG_RESET)
    else $error("read answer without a read");
endmodule

// ### design/lffe_pkg.sv
// Notes on behaviour
// - Six registers at addresses 0 to 5.
// - All fields are zero after reset.
// - Low-time code gives 1, 1, 2, 4 ms.
// - Alert on parity error, optionally alarm too.
// - Channel enabled while its bit is zero.
// - Output type picks demod, carrier or RSSI.
// - Tuning code adds 1 pF per step.
// - Pulldown follows its bit in RSSI mode.
// - Carrier clock divided by four when set.
// - Register 3 bits 8-7 read zero.
// - Sensitivity drops 2 dB per code step.
// - AGC gating holds demod until AGC regulates.
// - Modulation depth code gives 33/60/14/8 percent.
// - Parity error sets flag, pulls alert low.
// - Registers read and written by commands.
package lffe_pkg;
  localparam int unsigned LFFE_ADDR_W   = 4;
  localparam int unsigned LFFE_REG_W    = 9;
  localparam int unsigned LFFE_REG_N    = 6;
  localparam logic [3:0]  LFFE_ADDR_REG0 = 4'h0;
  localparam logic [3:0]  LFFE_ADDR_REG1 = 4'h1;
  localparam logic [3:0]  LFFE_ADDR_REG3 = 4'h3;
  localparam logic [3:0]  LFFE_ADDR_LAST = 4'h5;
  localparam logic [8:0]  LFFE_REG_RESET = 9'h000;
  localparam logic [8:0]  LFFE_REG3_MASK = 9'h07f;
  // Field positions
  localparam int unsigned LFFE_LOWT_LSB   = 5;
  localparam int unsigned LFFE_ALRT_BIT   = 4;
  localparam int unsigned LFFE_CHDIS_BIT  = 1;
  localparam int unsigned LFFE_OTYPE_LSB  = 7;
  localparam int unsigned LFFE_TUNE_LSB   = 1;
  localparam int unsigned LFFE_PULL_BIT   = 8;
  localparam int unsigned LFFE_CDIV_BIT   = 7;
  localparam int unsigned LFFE_SENS_LSB   = 5;
  localparam int unsigned LFFE_AGCG_BIT   = 7;
  localparam int unsigned LFFE_MODD_LSB   = 5;
  // Output type codes
  localparam logic [1:0]  LFFE_OTYPE_DEMOD = 2'h0;
  localparam logic [1:0]  LFFE_OTYPE_CARR  = 2'h1;
  // Timing
  localparam int unsigned LFFE_CLOCK_HZ    = 40000000;
  localparam int unsigned LFFE_BASE_MS     = 1;
  localparam int unsigned LFFE_MS_CYCLES   = LFFE_CLOCK_HZ / 1000 * LFFE_BASE_MS;
  localparam logic [2:0]  LFFE_LOWT_1MS    = 3'h1;
  localparam logic [2:0]  LFFE_LOWT_2MS    = 3'h2;
  localparam logic [2:0]  LFFE_LOWT_4MS    = 3'h4;
  localparam logic [1:0]  LFFE_CDIV_HALF   = 2'h1;
  // Modulation depth in percent
  localparam logic [6:0]  LFFE_MOD_33 = 7'h21;
  localparam logic [6:0]  LFFE_MOD_60 = 7'h3c;
  localparam logic [6:0]  LFFE_MOD_14 = 7'h0e;
  localparam logic [6:0]  LFFE_MOD_8  = 7'h08;
  // Synchronised pins
  localparam int unsigned LFFE_PIN_N     = 5;
  localparam int unsigned LFFE_PIN_DEMOD = 0;
  localparam int unsigned LFFE_PIN_CARR  = 1;
  localparam int unsigned LFFE_PIN_AGC   = 2;
  localparam int unsigned LFFE_PIN_RSSI  = 3;
  localparam int unsigned LFFE_PIN_ALARM = 4;

  function automatic logic [2:0] lffe_low_time_ms(input logic [1:0] code);
    case (code)
      2'h2:    lffe_low_time_ms = LFFE_LOWT_2MS;
      2'h3:    lffe_low_time_ms = LFFE_LOWT_4MS;
      default: lffe_low_time_ms = LFFE_LOWT_1MS;
    endcase
  endfunction

  function automatic logic [6:0] lffe_mod_depth(input logic [1:0] code);
    case (code)
      2'h1:    lffe_mod_depth = LFFE_MOD_60;
      2'h2:    lffe_mod_depth = LFFE_MOD_14;
      2'h3:    lffe_mod_depth = LFFE_MOD_8;
      default: lffe_mod_depth = LFFE_MOD_33;
    endcase
  endfunction
endpackage

// ### design/lffe_low_timer.sv
module lffe_low_timer
  import lffe_pkg::*;
#(
  parameter int unsigned MS_CYCLES = LFFE_MS_CYCLES
)
(
  // Clock and reset
  input  wire logic       i_clock,
  input  wire logic       i_reset,
  // Level and selection
  input  wire logic       i_level,
  input  wire logic [1:0] i_code,
  // Result
  output logic            o_met
);
  localparam int unsigned CW = $clog2(MS_CYCLES + 1);

  logic [CW-1:0] cycle_count;
  logic [2:0]    ms_count;
  wire           ms_tick = (cycle_count == CW'(MS_CYCLES - 1));
  wire [2:0]     target  = lffe_low_time_ms(i_code);

  // Any high level restarts the whole low-time measurement
  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
    begin
      cycle_count <= '0;
      ms_count    <= '0;
      o_met       <= 1'b0;
    end
    else if (i_level)
    begin
      cycle_count <= '0;
      ms_count    <= '0;
      o_met       <= 1'b0;
    end
    else
    begin
      cycle_count <= ms_tick ? '0 : cycle_count + 1'b1;
      if (ms_tick && ms_count < LFFE_LOWT_4MS)
        ms_count <= ms_count + 3'h1;
      o_met <= (ms_count >= target);
    end
  end
endmodule

// ### design/lffe_clock_divider.sv
module lffe_clock_divider
  import lffe_pkg::*;
(
  // Clock and reset
  input  wire logic i_clock,
  input  wire logic i_reset,
  // Carrier in and mode
  input  wire logic i_carrier,
  input  wire logic i_divide,
  // Carrier out
  output logic      o_clock
);
  logic       carrier_prev;
  logic [1:0] edge_count;
  logic       divided;
  wire        rise = i_carrier && !carrier_prev;

  // Two carrier periods per half period of the divided clock
  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
    begin
      carrier_prev <= 1'b0;
      edge_count   <= '0;
      divided      <= 1'b0;
    end
    else
    begin
      carrier_prev <= i_carrier;
      if (rise)
      begin
        edge_count <= (edge_count == LFFE_CDIV_HALF) ? 2'h0 : edge_count + 2'h1;
        if (edge_count == LFFE_CDIV_HALF)
          divided <= !divided;
      end
    end
  end

  assign o_clock = i_divide ? divided : i_carrier;
endmodule

// ### tb/lffe_host_model.sv
module lffe_host_model
  import lffe_pkg::*;
(
  // Clock
  input  wire logic       i_clock,
  // Register bus
  output logic            o_wr_strobe,
  output logic            o_rd_strobe,
  output logic      [3:0] o_addr,
  output logic      [8:0] o_wdata,
  input  wire logic [8:0] i_rdata,
  input  wire logic       i_rd_valid
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    o_wr_strobe = 1'b0;
    o_rd_strobe = 1'b0;
    o_addr      = 4'h0;
    o_wdata     = 9'h000;
  end

  // Parity is always made odd; only dropped bits can upset a row
  task automatic put(input logic [3:0] a, input logic [7:0] d);
    @(negedge i_clock);
    o_addr      = a;
    o_wdata     = {d, ~^d};
    o_wr_strobe = 1'b1;
    @(negedge i_clock);
    o_wr_strobe = 1'b0;
    // Released lines must not keep looking valid
    o_wdata     = ~o_wdata;
    o_addr      = ~o_addr;
  endtask

  task automatic get(input logic [3:0] a, output logic [8:0] d, output logic v);
    @(negedge i_clock);
    o_addr      = a;
    o_rd_strobe = 1'b1;
    @(negedge i_clock);
    o_rd_strobe = 1'b0;
    o_addr      = ~o_addr;
    d           = i_rdata;
    v           = i_rd_valid;
  endtask
endmodule

// ### tb/lffe_config_regs_tb.sv
module lffe_config_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clock = 1'b0;
  logic       reset = 1'b1;
  logic       wr, rd, rvalid, demod, carr, agc, rssi, alarm, pin, pull, chen, met, agca, perr, alert_n;
  logic [3:0] addr;
  logic [8:0] wdata, rdata;
  logic [5:0] tune;
  logic [4:0] sens;
  logic [6:0] depth;
  logic [2:0] lowt;
  int         mismatches = 0;
  int         n_checks = 0;
  int         cycles = 0;

  always #12.5 clock = ~clock;

  lffe_config_regs #(.MS_CYCLES(8)) u_dut (
    .I_CLOCK(clock), .I_RESET(reset), .I_WR_STROBE(wr), .I_RD_STROBE(rd),
    .I_ADDR(addr), .I_WDATA(wdata), .O_RDATA(rdata), .O_RD_VALID(rvalid),
    .I_DEMOD_DATA(demod), .I_CARRIER_CLOCK(carr), .I_AGC_REGULATING(agc),
    .I_RSSI_LEVEL(rssi), .I_ALARM_EXPIRED(alarm), .O_RECEIVE_DATA_PIN(pin),
    .O_SIGNAL_STRENGTH_PULLDOWN(pull), .O_CHANNEL_ENABLE(chen),
    .O_ANTENNA_TUNING_CAP(tune), .O_SENSITIVITY_CUT_DB(sens),
    .O_MIN_MODULATION_DEPTH(depth), .O_FILTER_LOW_TIME_MS(lowt),
    .O_FILTER_LOW_MET(met), .O_AGC_ACTIVE(agca), .O_PARITY_ERROR_FLAG(perr),
    .O_ALERT_N(alert_n));

  lffe_host_model u_host (
    .i_clock(clock), .o_wr_strobe(wr), .o_rd_strobe(rd), .o_addr(addr),
    .o_wdata(wdata), .i_rdata(rdata), .i_rd_valid(rvalid));

  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Ceiling is several times the expected run
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      mismatches++;
      conclude;
    end
  end

  task automatic chk(input logic [8:0] s, input logic [8:0] e);
    n_checks++;
    if (s !== e)
    begin
      mismatches++;
      $display("unexpected at %0t: saw %h wanted %h", $time, s, e);
    end
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [8:0] e);
    logic [8:0] d;
    logic       v;
    u_host.get(a, d, v);
    chk(v, 1'b1);
    chk(d, e);
  endtask

  // Pins pass a synchroniser, so give them margin
  task automatic settle;
    repeat (8) @(negedge clock);
  endtask

  task automatic t_reset;
    for (int a = 0; a < 6; a++)
      rd_chk(a[3:0], 9'h000);
    chk(chen, 1'b1);
    chk(perr, 1'b1);
    chk(alert_n, 1'b0);
  endtask

  task automatic t_regs;
    for (int a = 0; a < 6; a++)
    begin
      u_host.put(a[3:0], 8'hff);
      rd_chk(a[3:0], (a == 3) ? 9'h07f : 9'h1ff);
    end
    rd_chk(4'h6, 9'h000);
    rd_chk(4'hf, 9'h000);
    u_host.put(4'h8, 8'h00);
    rd_chk(4'h0, 9'h1ff);
    settle;
    chk(tune, 6'h3f);
    chk(sens, 5'h1e);
    chk(chen, 1'b0);
    chk(perr, 1'b0);
    u_host.put(4'h3, 8'h80);
    rd_chk(4'h3, 9'h000);
    settle;
    chk(perr, 1'b1);
    chk(alert_n, 1'b0);
    u_host.put(4'h3, 8'h00);
    settle;
    chk(alert_n, 1'b1);
    alarm = 1'b1;
    settle;
    chk(alert_n, 1'b0);
    u_host.put(4'h0, 8'h06);
    settle;
    chk(alert_n, 1'b1);
    chk(chen, 1'b1);
    alarm = 1'b0;
  endtask

  task automatic t_fields;
    logic [6:0] mt [4] = '{7'h21, 7'h3c, 7'h0e, 7'h08};
    logic [2:0] lt [4] = '{3'h1, 3'h1, 3'h2, 3'h4};
    for (int c = 0; c < 4; c++)
    begin
      u_host.put(4'h0, {2'b00, c[1:0], 4'h6});
      u_host.put(4'h5, {2'b00, c[1:0], 4'h0});
      settle;
      chk(lowt, lt[c]);
      chk(depth, mt[c]);
    end
    for (int c = 0; c < 16; c++)
    begin
      u_host.put(4'h4, {c[3:0], 4'h0});
      settle;
      chk(sens, 9'(2 * c));
    end
  endtask

  task automatic edges(input int e);
    int   n;
    logic last;
    n = 0;
    last = pin;
    for (int i = 0; i < 180; i++)
    begin
      @(negedge clock);
      if (i % 10 == 0 && i < 160)
        carr = ~carr;
      n += int'(pin && !last);
      last = pin;
    end
    chk(9'(n), 9'(e));
  endtask

  task automatic t_output;
    u_host.put(4'h1, 8'h00);
    demod = 1'b1;
    settle;
    chk(pin, 1'b1);
    chk(met, 1'b0);
    demod = 1'b0;
    rssi = 1'b1;
    u_host.put(4'h2, 8'h80);
    for (int t = 2; t < 4; t++)
    begin
      u_host.put(4'h1, {t[1:0], 6'h00});
      settle;
      chk(pin, 1'b1);
      chk(pull, 1'b1);
    end
    u_host.put(4'h1, 8'h00);
    rssi = 1'b0;
    settle;
    chk(pull, 1'b0);
    chk(pin, 1'b0);
    chk(tune, 6'h00);
    chk(met, 1'b0);
    // Low time of 4 ms is 32 cycles at the reduced scale
    repeat (40) @(negedge clock);
    chk(met, 1'b1);
    u_host.put(4'h1, 8'h40);
    u_host.put(4'h2, 8'h00);
    settle;
    edges(8);
    u_host.put(4'h2, 8'h40);
    settle;
    edges(2);
  endtask

  task automatic t_agc;
    u_host.put(4'h1, 8'h00);
    u_host.put(4'h5, 8'h40);
    demod = 1'b1;
    settle;
    chk(pin, 1'b0);
    chk(agca, 1'b0);
    agc = 1'b1;
    settle;
    chk(pin, 1'b1);
    chk(agca, 1'b1);
    u_host.put(4'h0, 8'h07);
    settle;
    chk(pin, 1'b0);
    chk(chen, 1'b0);
  endtask

  initial
  begin
    demod = 1'b0;
    carr = 1'b0;
    agc = 1'b0;
    rssi = 1'b0;
    alarm = 1'b0;
    repeat (5) @(negedge clock);
    reset = 1'b0;
    t_reset;
    t_regs;
    t_fields;
    t_output;
    t_agc;
    conclude;
  end
endmodule
